/* File: hdl/ram_alarm.sv */
// Alarm match, sticky alarm flag and shared open-drain interrupt pin
`timescale 1ns/1ps
module ram_alarm (
  input wire logic clk,
  input wire logic rst,
  input wire logic minute_tick,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [6:0] cur_week,
  input wire logic [5:0] cur_date,
  input wire logic clock_stop,
  input wire logic count_reset,
  input wire logic timer_event,
  input wire logic reg_we,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic irq_n_out,
  output logic irq_n_oe
);
  import ram_pkg::*;
  typedef struct packed {
    logic [7:0] min_set;
    logic [7:0] hour_set;
    logic [7:0] wday_set;
    logic week_or_date_select;
    logic alarm_flag;
    logic timer_flag;
    logic alarm_irq_enable;
    logic timer_irq_enable;
    logic [7:0] rdata;
    logic irq_oe;
  } ram_state_s;
  ram_state_s st_ff;
  ram_state_s nxt_st;
  logic hit;
  logic alarm_event;
  ram_match u_match (
    .min_set(st_ff.min_set),
    .hour_set(st_ff.hour_set),
    .wday_set(st_ff.wday_set),
    .week_or_date_select(st_ff.week_or_date_select),
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .cur_week(cur_week),
    .cur_date(cur_date),
    .hit(hit)
  );
  // Only on counter advance, never on register write
  assign alarm_event = minute_tick && hit && !clock_stop && !count_reset;
  always_comb begin
    nxt_st = st_ff;
    if (reg_we) begin
      case (reg_addr)
        RAM_MIN_OFF: nxt_st.min_set = reg_wdata;
        RAM_HOUR_OFF: nxt_st.hour_set = reg_wdata;
        RAM_WDAY_OFF: nxt_st.wday_set = reg_wdata;
        RAM_EXT_OFF: nxt_st.week_or_date_select = reg_wdata[RAM_SEL_BIT];
        RAM_FLAG_OFF: begin
          if (!reg_wdata[RAM_ALARM_FLAG_BIT]) begin
            nxt_st.alarm_flag = 1'b0;
          end
          if (!reg_wdata[RAM_TIMER_FLAG_BIT]) begin
            nxt_st.timer_flag = 1'b0;
          end
        end
        RAM_CTRL_OFF: begin
          nxt_st.alarm_irq_enable = reg_wdata[RAM_ALARM_EN_BIT];
          nxt_st.timer_irq_enable = reg_wdata[RAM_TIMER_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    // Set wins over clear
    if (alarm_event) begin
      nxt_st.alarm_flag = 1'b1;
    end
    if (timer_event) begin
      nxt_st.timer_flag = 1'b1;
    end
    case (reg_addr)
      RAM_MIN_OFF: nxt_st.rdata = nxt_st.min_set;
      RAM_HOUR_OFF: nxt_st.rdata = nxt_st.hour_set;
      RAM_WDAY_OFF: nxt_st.rdata = nxt_st.wday_set;
      RAM_EXT_OFF: nxt_st.rdata = {1'b0, nxt_st.week_or_date_select, 6'h00};
      RAM_FLAG_OFF: nxt_st.rdata = {3'h0, nxt_st.timer_flag, nxt_st.alarm_flag, 3'h0};
      RAM_CTRL_OFF: nxt_st.rdata = {3'h0, nxt_st.timer_irq_enable,
                                    nxt_st.alarm_irq_enable, 3'h0};
      default: nxt_st.rdata = 8'h00;
    endcase
    nxt_st.irq_oe = (nxt_st.alarm_flag && nxt_st.alarm_irq_enable)
                 || (nxt_st.timer_flag && nxt_st.timer_irq_enable);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.min_set <= RAM_ALARM_RST;
      st_ff.hour_set <= RAM_ALARM_RST;
      st_ff.wday_set <= RAM_ALARM_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign reg_rdata = st_ff.rdata;
  assign irq_n_oe = st_ff.irq_oe;
  assign irq_n_out = 1'b0;
endmodule : ram_alarm

/* File: hdl/ram_pkg.sv */
// Package with register map, field positions and reset values for the alarm match unit
package ram_pkg;
  localparam logic [3:0] RAM_MIN_OFF = 4'h8;
  localparam logic [3:0] RAM_HOUR_OFF = 4'h9;
  localparam logic [3:0] RAM_WDAY_OFF = 4'ha;
  localparam logic [3:0] RAM_EXT_OFF = 4'hd;
  localparam logic [3:0] RAM_FLAG_OFF = 4'he;
  localparam logic [3:0] RAM_CTRL_OFF = 4'hf;
  localparam int RAM_DIS_BIT = 7;
  localparam int RAM_SEL_BIT = 6;
  localparam int RAM_TIMER_FLAG_BIT = 4;
  localparam int RAM_ALARM_FLAG_BIT = 3;
  localparam int RAM_TIMER_EN_BIT = 4;
  localparam int RAM_ALARM_EN_BIT = 3;
  localparam logic [7:0] RAM_ALARM_RST = 8'h00;
  localparam logic [5:0] RAM_DATE_MASK = 6'h3f;
  localparam logic [6:0] RAM_WEEK_MASK = 7'h7f;
endpackage : ram_pkg

/* File: hdl/ram_match.sv */
// Combinational alarm field comparator
`timescale 1ns/1ps
module ram_match (
  input wire logic [7:0] min_set,
  input wire logic [7:0] hour_set,
  input wire logic [7:0] wday_set,
  input wire logic week_or_date_select,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [6:0] cur_week,
  input wire logic [5:0] cur_date,
  output logic hit
);
  import ram_pkg::*;
  logic min_ok;
  logic hour_ok;
  logic day_ok;
  always_comb begin
    min_ok = min_set[RAM_DIS_BIT] || (min_set[6:0] == cur_min);
    hour_ok = hour_set[RAM_DIS_BIT] || (hour_set[5:0] == cur_hour);
    if (wday_set[RAM_DIS_BIT]) begin
      day_ok = 1'b1;
    end else if (week_or_date_select) begin
      day_ok = ((wday_set[5:0] & RAM_DATE_MASK) == cur_date);
    end else begin
      day_ok = |(wday_set[6:0] & cur_week & RAM_WEEK_MASK);
    end
    hit = min_ok && hour_ok && day_ok;
  end
endmodule : ram_match

/* File: verif/ram_host.sv */
// Host side of the pulled-up shared interrupt line
`timescale 1ns/1ps
module ram_host (input wire logic irq_n_out, input wire logic irq_n_oe, output logic irq_pin);
  assign irq_pin = irq_n_oe ? irq_n_out : 1'b1;
endmodule : ram_host

/* File: verif/ram_alarm_assertions.sv */
// Alarm unit port checks
`timescale 1ns/1ps
module ram_alarm_chk (input wire logic clk, rst, minute_tick, clock_stop, count_reset,
  timer_event, reg_we, irq_n_out, irq_n_oe, input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic p;
  wire f = reg_addr == 4'he;
  wire v = p && f;
  wire a = reg_rdata[3];
  always_ff @(posedge clk) p <= f;
  property p_od; !irq_n_out; endproperty
  a_od: assert property (p_od) else $error("od");
  property p_up; $rose(irq_n_oe) |-> $past(minute_tick | timer_event | reg_we); endproperty
  a_up: assert property (p_up) else $error("up");
  property p_dn; $fell(irq_n_oe) |-> $past(reg_we); endproperty
  a_dn: assert property (p_dn) else $error("dn");
  property p_hd; v && a && !(reg_we && !reg_wdata[3]) |=> a; endproperty
  a_hd: assert property (p_hd) else $error("hd");
  property p_st; v && !a && !(minute_tick && !clock_stop && !count_reset) |=> !a; endproperty
  a_st: assert property (p_st) else $error("st");
  property p_cl; reg_we && f && !reg_wdata[3] && !minute_tick |=> !a; endproperty
  a_cl: assert property (p_cl) else $error("cl");
  property p_of; reg_we && reg_addr == 4'hf && reg_wdata[4:3] == 2'h0 |=> !irq_n_oe; endproperty
  a_of: assert property (p_of) else $error("of");
  property p_tm; timer_event && f && !reg_we |=> reg_rdata[4]; endproperty
  a_tm: assert property (p_tm) else $error("tm");
endmodule : ram_alarm_chk
bind ram_alarm ram_alarm_chk i_ram_alarm_chk (.*);

/* File: verif/tb.sv */
// Alarm unit bench
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, minute_tick = 0, clock_stop = 0, count_reset = 0, timer_event = 0;
  logic reg_we = 0, irq_n_out, irq_n_oe, irq_pin;
  logic [6:0] cur_min = 0, cur_week = 0;
  logic [5:0] cur_hour = 0, cur_date = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  int errors = 0, num_checks = 0, n = 0;
  ram_alarm i_ram_alarm (.*);
  ram_host i_ram_host (.*);
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (++n > 900) begin errors++; stop_test(); end
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) #1 {reg_we, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #1 reg_we = 0;
  endtask : wr
  task cmp_state(input logic k, input logic [6:0] m, x, input logic [5:0] h,
    input logic [7:0] e);
    @(posedge clk) #1 {minute_tick, timer_event, cur_min, cur_week} = {k, 1'b0, m, x};
    {cur_hour, cur_date} = {h, x[5:0]};
    @(posedge clk) #1 {minute_tick, reg_addr} = 5'h0e;
    @(posedge clk) #1 num_checks++;
    if ((reg_rdata & 8'h18 | irq_pin) !== e) begin
      errors++;
      $display("Error %0t %h %h", $time, e, reg_rdata & 8'h18 | irq_pin);
    end
  endtask : cmp_state
  task t_a;
    wr(4'hf, 8'h08); wr(4'h8, 8'h59); wr(4'h9, 8'h18); wr(4'ha, 8'h22);
    cmp_state(1, 7'h59, 7'h04, 6'h18, 8'h01);
    cmp_state(1, 7'h59, 7'h20, 6'h06, 8'h01);
    cmp_state(1, 7'h59, 7'h20, 6'h18, 8'h08);
    wr(4'he, 8'h00); wr(4'hd, 8'h40); wr(4'ha, 8'h15);
    cmp_state(1, 7'h59, 7'h14, 6'h18, 8'h01);
    cmp_state(1, 7'h59, 7'h15, 6'h18, 8'h08);
    wr(4'he, 8'h18);
    cmp_state(1, 7'h59, 7'h15, 6'h18, 8'h08);
  endtask : t_a
  task t_b;
    wr(4'hf, 8'h00);
    cmp_state(0, 7'h00, 7'h00, 6'h00, 8'h09);
    wr(4'he, 8'h00); wr(4'ha, 8'h80);
    cmp_state(1, 7'h59, 7'h00, 6'h18, 8'h09);
    wr(4'he, 8'h00); wr(4'h8, 8'h80); wr(4'h9, 8'h80);
    cmp_state(1, 7'h03, 7'h00, 6'h02, 8'h09);
    wr(4'hf, 8'h10);
    {timer_event, reg_addr} = 5'h1e;
    cmp_state(0, 7'h00, 7'h00, 6'h00, 8'h18);
    wr(4'he, 8'h10);
    cmp_state(0, 7'h00, 7'h00, 6'h00, 8'h10);
    wr(4'hf, 8'h00);
    cmp_state(0, 7'h00, 7'h00, 6'h00, 8'h11);
    wr(4'he, 8'h00);
    cmp_state(0, 7'h00, 7'h00, 6'h00, 8'h01);
    clock_stop = 1;
    cmp_state(1, 7'h00, 7'h00, 6'h00, 8'h01);
    {clock_stop, count_reset} = 2'b01;
    cmp_state(1, 7'h00, 7'h00, 6'h00, 8'h01);
  endtask : t_b
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    t_a();
    $display("t_a done");
    t_b();
    $display("t_b done");
    stop_test();
  end
endmodule : tb
